// >>> include/ecc_pkg.sv
// shared constants, field layout and helpers for the element configuration control block
package ecc_pkg;

    // configuration control register layout
    localparam int CFG_W        = 22;
    localparam int STATE_LSB    = 0;
    localparam int STATE_W      = 2;
    localparam int AUTH_LSB     = 2;
    localparam int AUTH_W       = 3;
    localparam int HALT_INH_BIT = 5;
    localparam int STOR_LSB     = 6;
    localparam int STOR_W       = 10;
    localparam int CE_LSB       = 16;
    localparam int CE_W         = 3;
    localparam int IOC_LSB      = 19;
    localparam int IOC_W        = 3;
    localparam int PEER_W       = STOR_W + CE_W + IOC_W;

    localparam logic [STATE_W-1:0] STATE_IDLE = 2'h0;
    localparam logic [STATE_W-1:0] STATE_OP   = 2'h3;
    localparam logic [CFG_W-1:0]   CFG_RESET  = 22'h000000;

    // register map, byte addresses
    localparam int ADR_W          = 8;
    localparam logic [ADR_W-1:0] ADR_CFG    = 8'h00;
    localparam logic [ADR_W-1:0] ADR_STATUS = 8'h04;

    // status bits
    localparam int ST_TEST     = 0;
    localparam int ST_ACCEPTED = 1;
    localparam int ST_REFUSED  = 2;
    localparam int ST_W        = 3;

    typedef enum logic [1:0] {
        ELEM_CE   = 2'b00,
        ELEM_IOC  = 2'b01,
        ELEM_STOR = 2'b10,
        ELEM_UNIT = 2'b11
    } ecc_elem_type;

    // field group masks
    localparam logic [CFG_W-1:0] M_STATE    = 22'h000003;
    localparam logic [CFG_W-1:0] M_AUTH     = 22'h00001c;
    localparam logic [CFG_W-1:0] M_HALT_INH = 22'h000020;
    localparam logic [CFG_W-1:0] M_STOR     = 22'h00ffc0;
    localparam logic [CFG_W-1:0] M_CE       = 22'h070000;
    localparam logic [CFG_W-1:0] M_IOC      = 22'h380000;

    // bits a given element type actually receives from a reconfiguration
    function automatic logic [CFG_W-1:0] ecc_apply_mask(input ecc_elem_type t);
        logic [CFG_W-1:0] m;
        m = M_STATE | M_AUTH;
        case (t)
            ELEM_CE:   m = m | M_HALT_INH | M_STOR | M_IOC;
            ELEM_IOC:  m = m | M_HALT_INH | M_STOR | M_CE;
            ELEM_STOR: m = m | M_CE | M_IOC;
            default:   m = m | M_IOC;
        endcase
        return m;
    endfunction

    // an empty authority field must never lock the element out
    function automatic logic [AUTH_W-1:0] ecc_eff_auth(input logic [AUTH_W-1:0] a);
        return (a == '0) ? {AUTH_W{1'b1}} : a;
    endfunction

endpackage

// >>> include/ecc_sw_if.sv
// carrier between the test switch conditioner and the register logic
`timescale 1ns/1ps
`default_nettype none
interface ecc_sw_if;
    logic testOn;
    logic testLeft;
    modport source (output testOn, output testLeft);
    modport sink   (input testOn, input testLeft);
endinterface
`default_nettype wire

// >>> verilog/ecc_test_switch.sv
// test switch synchroniser: level and leave pulse
`timescale 1ns/1ps
`default_nettype none
module ecc_test_switch (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // raw pin
    input  wire logic testSwitchPin,
    // conditioned outputs
    ecc_sw_if.source  sw
);
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic on;
        logic left;
    } ecc_sw_state_type;

    ecc_sw_state_type stateQ;
    ecc_sw_state_type stateD;

    always_comb begin
        stateD      = stateQ;
        stateD.ff1  = testSwitchPin;
        stateD.ff2  = stateQ.ff1;
        stateD.ff3  = stateQ.ff2;
        stateD.left = 1'b0;
        // a change counts only once the second and third stages agree
        if (stateQ.ff2 == stateQ.ff3) begin
            stateD.on   = stateQ.ff3;
            stateD.left = stateQ.on & ~stateQ.ff3;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= '0;
        end else begin
            stateQ <= stateD;
        end
    end

    assign sw.testOn   = stateQ.on;
    assign sw.testLeft = stateQ.left;
endmodule
`default_nettype wire

// >>> verilog/ecc_element_ccr.sv
// configuration control register of one system element with wishbone access
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RQ1) state bits 11 mean state three, the operational state
// (RQ2) issuer only executes reconfiguration in state three or zero
// (RQ3) reconfiguration accepted only from a computing element set in authority field
// (RQ4) selected element loads state, authority and communication bits from the mask
// (RQ5) only bits applicable to the element type are delivered
// (RQ6) set communication bit lets the element listen to that peer
// (RQ7) test switch on: reconfiguration is refused, element stays isolated; the code still grants peers from the communication bits in test position
// (RQ8) program clears a computing element's bit in storage before its power cycle
// (RQ9) empty authority field is treated as all ones
// (RQ10) leaving test position resets the state bits to 00 unless a reconfiguration is accepted in the same cycle
// (RQ11) issuer rejects masks with an empty authority field
// (RQ12) fields not applicable to the type keep their values
module ecc_element_cfg #(
    parameter ecc_pkg::ecc_elem_type ELEM_TYPE = ecc_pkg::ELEM_STOR
) (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    // wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ecc_pkg::ADR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // reconfiguration instruction from a computing element
    input  wire logic                          reconfValid,
    input  wire logic                          reconfSelect,
    input  wire logic [ecc_pkg::AUTH_W-1:0]    reconfIssuer,
    input  wire logic [ecc_pkg::CFG_W-1:0]     reconfMask,
    output logic                               reconfAccepted,
    output logic                               reconfRefused,
    // test switch pin
    input  wire logic                          testSwitchPin,
    // peer interfaces and element state
    input  wire logic [ecc_pkg::PEER_W-1:0]    peerReq,
    output logic      [ecc_pkg::PEER_W-1:0]    peerGrant,
    output logic      [ecc_pkg::CFG_W-1:0]     cfgOut,
    output logic                               opState3
);
    localparam logic [ecc_pkg::CFG_W-1:0] APPLY = ecc_pkg::ecc_apply_mask(ELEM_TYPE);

    typedef struct packed {
        logic [ecc_pkg::CFG_W-1:0]  cfg;
        logic [ecc_pkg::PEER_W-1:0] grant;
        logic                       opState3;
        logic                       accepted;
        logic                       refused;
        logic                       stickyAcc;
        logic                       stickyRef;
        logic                       ack;
        logic [31:0]                rdata;
    } ecc_cfg_state_type;

    ecc_cfg_state_type stateQ;
    ecc_cfg_state_type stateD;
    ecc_sw_if          sw ();

    logic                         wbReq;
    logic                         wbWrite;
    logic                         authorised;
    logic                         acceptNow;
    logic                         refuseNow;
    logic [ecc_pkg::PEER_W-1:0]   commBits;

    ecc_test_switch u_switch (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .testSwitchPin (testSwitchPin),
        .sw            (sw)
    );

    assign wbReq      = wb_cyc_i & wb_stb_i & ~stateQ.ack;
    // write lands on the edge where the master sees ack, request still held
    assign wbWrite    = wb_cyc_i & wb_stb_i & wb_we_i & stateQ.ack;
    assign authorised = |(reconfIssuer & ecc_pkg::ecc_eff_auth(
                          stateQ.cfg[ecc_pkg::AUTH_LSB +: ecc_pkg::AUTH_W])); // RQ3 RQ9
    assign acceptNow  = reconfValid & reconfSelect & authorised & ~sw.testOn; // RQ3 RQ7
    assign refuseNow  = reconfValid & reconfSelect & ~acceptNow;
    assign commBits   = stateQ.cfg[ecc_pkg::CFG_W-1:ecc_pkg::STOR_LSB];

    always_comb begin
        stateD          = stateQ;
        stateD.accepted = acceptNow;
        stateD.refused  = refuseNow;
        stateD.ack      = wbReq;
        if (acceptNow) begin
            // non-applicable fields hold their old contents
            stateD.cfg = (stateQ.cfg & ~APPLY) | (reconfMask & APPLY); // RQ4 RQ5 RQ12
        end else if (sw.testLeft) begin
            // keeps manual control from being lost after maintenance
            stateD.cfg[ecc_pkg::STATE_LSB +: ecc_pkg::STATE_W] = ecc_pkg::STATE_IDLE; // RQ10
        end
        stateD.grant    = peerReq & commBits; // RQ6
        stateD.opState3 = (stateQ.cfg[ecc_pkg::STATE_LSB +: ecc_pkg::STATE_W]
                           == ecc_pkg::STATE_OP); // RQ1
        stateD.rdata    = 32'h00000000;
        if (wbWrite && wb_adr_i == ecc_pkg::ADR_STATUS && wb_sel_i[0]) begin
            if (wb_dat_i[ecc_pkg::ST_ACCEPTED]) begin
                stateD.stickyAcc = 1'b0;
            end
            if (wb_dat_i[ecc_pkg::ST_REFUSED]) begin
                stateD.stickyRef = 1'b0;
            end
        end
        if (wbReq && !wb_we_i && wb_adr_i == ecc_pkg::ADR_CFG) begin
            stateD.rdata[ecc_pkg::CFG_W-1:0] = stateQ.cfg;
        end else if (wbReq && !wb_we_i && wb_adr_i == ecc_pkg::ADR_STATUS) begin
            stateD.rdata[ecc_pkg::ST_TEST]     = sw.testOn;
            stateD.rdata[ecc_pkg::ST_ACCEPTED] = stateQ.stickyAcc;
            stateD.rdata[ecc_pkg::ST_REFUSED]  = stateQ.stickyRef;
        end
        // an event in the clearing cycle wins over the clear
        if (acceptNow) begin
            stateD.stickyAcc = 1'b1;
        end
        if (refuseNow) begin
            stateD.stickyRef = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ     <= '0;
            stateQ.cfg <= ecc_pkg::CFG_RESET;
        end else begin
            stateQ <= stateD;
        end
    end

    assign wb_dat_o       = stateQ.rdata;
    assign wb_ack_o       = stateQ.ack;
    assign reconfAccepted = stateQ.accepted;
    assign reconfRefused  = stateQ.refused;
    assign peerGrant      = stateQ.grant;
    assign cfgOut         = stateQ.cfg;
    assign opState3       = stateQ.opState3;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_state3;
        (cfgOut[ecc_pkg::STATE_LSB +: ecc_pkg::STATE_W] == ecc_pkg::STATE_OP) |=> opState3;
    endproperty
    a_state3: assert property (p_state3) else $error("state 11 not reported"); // RQ1

    // a test-leave in the same cycle may legally rewrite the state bits
    property p_auth;
        (reconfValid && reconfSelect && !authorised && !sw.testLeft)
            |=> !reconfAccepted && $stable(cfgOut);
    endproperty
    a_auth: assert property (p_auth) else $error("unauthorised reconfiguration took effect"); // RQ3

    property p_load;
        acceptNow |=> ((cfgOut & APPLY) == ($past(reconfMask) & APPLY)) && reconfAccepted;
    endproperty
    a_load: assert property (p_load) else $error("mask not loaded"); // RQ4

    property p_type;
        ##1 ((cfgOut & ~APPLY) == ($past(cfgOut) & ~APPLY));
    endproperty
    a_type: assert property (p_type) else $error("foreign field changed"); // RQ5

    property p_keep;
        acceptNow ##1 1'b1 |-> ##1 ((cfgOut & ~APPLY) == ($past(cfgOut, 2) & ~APPLY));
    endproperty
    a_keep: assert property (p_keep) else $error("foreign field not kept"); // RQ12

    property p_listen;
        ##1 ((peerGrant & ~$past(commBits)) == '0);
    endproperty
    a_listen: assert property (p_listen) else $error("grant to ignored peer"); // RQ6

    property p_test;
        (sw.testOn && reconfValid && reconfSelect) |=> reconfRefused && !reconfAccepted;
    endproperty
    a_test: assert property (p_test) else $error("reconfiguration in test position"); // RQ7

    property p_empty;
        (reconfValid && reconfSelect && !sw.testOn && reconfIssuer != '0
         && cfgOut[ecc_pkg::AUTH_LSB +: ecc_pkg::AUTH_W] == '0) |=> reconfAccepted;
    endproperty
    a_empty: assert property (p_empty) else $error("empty authority not all ones"); // RQ9

    property p_leave;
        (sw.testLeft && !acceptNow)
            |=> (cfgOut[ecc_pkg::STATE_LSB +: ecc_pkg::STATE_W] == ecc_pkg::STATE_IDLE);
    endproperty
    a_leave: assert property (p_leave) else $error("state not reset after test"); // RQ10

    c_accept: cover property (acceptNow ##1 opState3);
    c_refuse: cover property (refuseNow && sw.testOn);
    c_leave:  cover property (sw.testLeft);
    c_clear:  cover property (wbWrite && acceptNow);
endmodule
`default_nettype wire

// >>> verilog/_unused_marker_removed.sv
// intentionally empty design unit holder
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> bench/ecc_issuer_model.sv
// issuing computing element model that drives reconfiguration instructions
`timescale 1ns/1ps
`default_nettype none
module ecc_issuer_model (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    // command from the bench
    input  wire logic                       issue,
    input  wire logic [1:0]                 issuerState,
    input  wire logic                       pick,
    input  wire logic [ecc_pkg::AUTH_W-1:0] issuerId,
    input  wire logic [ecc_pkg::CFG_W-1:0]  cfgMask,
    // toward the element
    output logic                            reconfValid,
    output logic                            reconfSelect,
    output logic      [ecc_pkg::AUTH_W-1:0] reconfIssuer,
    output logic      [ecc_pkg::CFG_W-1:0]  reconfMask,
    output logic                            specInt
);
    logic canRun;
    logic authOk;
    assign canRun = (issuerState == 2'h3) || (issuerState == 2'h0);
    assign authOk = (cfgMask & ecc_pkg::M_AUTH) != 22'h000000;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reconfValid  <= 1'b0;
            reconfSelect <= 1'b0;
            reconfIssuer <= 3'h0;
            reconfMask   <= 22'h000000;
            specInt      <= 1'b0;
        end else begin
            reconfValid  <= issue && canRun && authOk;
            reconfSelect <= issue && pick;
            specInt      <= issue && canRun && !authOk;
            // released lines toggle so a stale value never passes as live
            reconfIssuer <= issue ? issuerId : ~reconfIssuer;
            reconfMask   <= issue ? cfgMask : ~reconfMask;
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_element_configuration_control.sv
// self-checking bench for the element configuration register, storage element type
`timescale 1ns/1ps
`default_nettype none
module tb_element_configuration_control;
    typedef struct packed {
        logic [1:0]  st;
        logic        pk;
        logic [2:0]  id;
        logic [21:0] mask;
        logic [21:0] cfg;
        logic        acc;
        logic        rej;
        logic        spec;
        logic        op;
    } ecc_row_type;
    logic        ref_clk, rst_n, issue, wbCyc, wbStb, wbWe, wbAck, testPin;
    logic        reconfValid, reconfSelect, reconfAccepted, reconfRefused, specInt, opState3;
    logic [2:0]  reconfIssuer;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDat, wbDatO, rdData;
    logic [21:0] reconfMask, cfgOut;
    logic [15:0] peerReq, peerGrant;
    ecc_row_type cmd;
    int          numErrors, testsRun;
    ecc_row_type rows [10] = '{
        '{2'h3, 1'b1, 3'h1, 22'h3fffff, 22'h3f001f, 1'b1, 1'b0, 1'b0, 1'b1},
        '{2'h3, 1'b1, 3'h2, 22'h090007, 22'h090007, 1'b1, 1'b0, 1'b0, 1'b1},
        '{2'h3, 1'b1, 3'h2, 22'h3f001f, 22'h090007, 1'b0, 1'b1, 1'b0, 1'b1},
        '{2'h0, 1'b1, 3'h1, 22'h000003, 22'h090007, 1'b0, 1'b0, 1'b1, 1'b1},
        '{2'h1, 1'b1, 3'h1, 22'h3f001f, 22'h090007, 1'b0, 1'b0, 1'b0, 1'b1},
        '{2'h3, 1'b0, 3'h1, 22'h3f001f, 22'h090007, 1'b0, 1'b0, 1'b0, 1'b1},
        '{2'h0, 1'b1, 3'h1, 22'h050010, 22'h050010, 1'b1, 1'b0, 1'b0, 1'b0},
        '{2'h3, 1'b1, 3'h4, 22'h050013, 22'h050013, 1'b1, 1'b0, 1'b0, 1'b1},
        '{2'h3, 1'b1, 3'h1, 22'h3f001f, 22'h050013, 1'b0, 1'b1, 1'b0, 1'b1},
        // drop the first computing element's bit before it is power cycled
        '{2'h3, 1'b1, 3'h4, 22'h040013, 22'h040013, 1'b1, 1'b0, 1'b0, 1'b1}};
    ecc_issuer_model u_issuer (.ref_clk(ref_clk), .rst_n(rst_n), .issue(issue),
        .issuerState(cmd.st), .pick(cmd.pk), .issuerId(cmd.id), .cfgMask(cmd.mask),
        .reconfValid(reconfValid), .reconfSelect(reconfSelect), .reconfIssuer(reconfIssuer),
        .reconfMask(reconfMask), .specInt(specInt));
    ecc_element_cfg u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .reconfValid(reconfValid),
        .reconfSelect(reconfSelect), .reconfIssuer(reconfIssuer), .reconfMask(reconfMask),
        .reconfAccepted(reconfAccepted), .reconfRefused(reconfRefused),
        .testSwitchPin(testPin), .peerReq(peerReq), .peerGrant(peerGrant),
        .cfgOut(cfgOut), .opState3(opState3));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic ok, input string msg);
        testsRun++;
        if (ok !== 1'b1) begin
            numErrors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe  <= w;
        wbAdr <= a;
        wbDat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        rdData = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 50) begin
            numErrors++;
            $display("FAIL %0t bus timeout", $time);
            results();
        end
    endtask
    task automatic runRow(input ecc_row_type r);
        @(posedge ref_clk);
        cmd   <= r;
        issue <= 1'b1;
        @(posedge ref_clk);
        issue <= 1'b0;
        #1;
        check(specInt === r.spec, "empty authority not caught");
        @(posedge ref_clk);
        #1;
        check(reconfAccepted === r.acc && reconfRefused === r.rej, "answer pulse");
        check(cfgOut === r.cfg, "register contents");
        @(posedge ref_clk);
        #1;
        check(opState3 === r.op, "state three flag");
    endtask
    initial begin
        {rst_n, issue, wbCyc, wbStb, wbWe, testPin} = 6'h00;
        {wbAdr, wbDat, peerReq, cmd} = '0;
        wbSel = 4'hf;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check(cfgOut === 22'h000000, "reset value");
        // first row relies on the empty authority field reading as all ones
        foreach (rows[i]) begin
            runRow(rows[i]);
            $display("row %0d done", i);
        end
        @(posedge ref_clk);
        peerReq <= 16'hffff;
        @(posedge ref_clk);
        #1;
        check(peerGrant === 16'h1000, "peer gating");
        $display("peer test done");
        testPin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        wb(1'b0, 8'h04, 32'h0);
        check(rdData === 32'h7, "status with switch on");
        runRow('{2'h3, 1'b1, 3'h4, 22'h050010, 22'h040013, 1'b0, 1'b1, 1'b0, 1'b1});
        testPin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        check(cfgOut === 22'h040010 && opState3 === 1'b0, "state after test");
        $display("test switch done");
        // without byte lane 0 the clear must not land
        wbSel <= 4'he;
        wb(1'b1, 8'h04, 32'h4);
        wbSel <= 4'hf;
        wb(1'b0, 8'h04, 32'h0);
        check(rdData === 32'h6, "clear without lane 0");
        wb(1'b1, 8'h04, 32'h4);
        wb(1'b0, 8'h04, 32'h0);
        check(rdData === 32'h2, "refused flag clear");
        wb(1'b1, 8'h00, 32'hffffffff);
        wb(1'b0, 8'h00, 32'h0);
        check(rdData === 32'h040010, "register read only");
        wb(1'b0, 8'h08, 32'h0);
        check(rdData === 32'h0, "unmapped read");
        $display("bus test done");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(cfgOut === 22'h0 && peerGrant === 16'h0 && opState3 === 1'b0, "mid reset");
        rst_n <= 1'b1;
        wb(1'b0, 8'h04, 32'h0);
        check(rdData === 32'h0 && reconfAccepted === 1'b0, "flags after second release");
        $display("reset test done");
        results();
    end
endmodule
`default_nettype wire
